// ---- hdl/sdadc_pkg.sv ----
// Shared constants for the dual sigma-delta converter configuration block.
// Assumes a single 25 MHz core clock and byte-wide special-function-register access.
package sdadc_pkg;

  // Register addresses in the special-function-register space.
  localparam logic [7:0] PRIMARY_CONVERTER_CONTROL_ADDR = 8'hD2;
  localparam logic [7:0] AUX_CONVERTER_CONTROL_ADDR = 8'hD3;
  localparam logic [7:0] DECIMATION_RATE_ADDR = 8'hD4;

  // Reset values, and the decimation factor forced during calibration.
  localparam logic [7:0] PRIMARY_CONVERTER_CONTROL_RST = 8'h07;
  localparam logic [7:0] AUX_CONVERTER_CONTROL_RST = 8'h00;
  localparam logic [7:0] DECIMATION_RATE_RST = 8'h45;
  localparam logic [7:0] DECIMATION_CAL = 8'hFF;

  // Writable bits; everything else reads as zero.
  localparam logic [7:0] PRIMARY_CONTROL_MASK = 8'h7F;
  localparam logic [7:0] AUX_CONTROL_MASK = 8'h78;

  // Field positions in the primary converter control register.
  localparam int PRI_EXT_REF_BIT = 6;
  localparam int PRI_CH_HI = 5;
  localparam int PRI_CH_LO = 4;
  localparam int PRI_UNI_BIT = 3;
  localparam int PRI_RANGE_HI = 2;
  localparam int PRI_RANGE_LO = 0;

  // Field positions in the auxiliary converter control register.
  localparam int AUX_EXT_REF_BIT = 6;
  localparam int AUX_CH_HI = 5;
  localparam int AUX_CH_LO = 4;
  localparam int AUX_UNI_BIT = 3;

  // Auxiliary channel codes.
  localparam logic [1:0] AUX_CH_INPUT_THREE = 2'h0;
  localparam logic [1:0] AUX_CH_INPUT_FOUR = 2'h1;
  localparam logic [1:0] AUX_CH_TEMP_SENSOR = 2'h2;
  localparam logic [1:0] AUX_CH_INPUT_FIVE = 2'h3;

  // Output coding of a zero input.
  localparam logic [23:0] PRIMARY_BIPOLAR_ZERO = 24'h800000;
  localparam logic [15:0] AUX_BIPOLAR_ZERO = 16'h8000;

  // Timing: update rate is modulator clock over (3 * 8 * decimation factor).
  localparam int CLK_HZ = 25_000_000;
  localparam int MOD_HZ = 32_768;
  localparam int DEC_MULT = 3 * 8;
  localparam int FIRST_RESULT_PERIODS = 2;
  localparam int MOD_ACC_W = $clog2(CLK_HZ) + 1;

endpackage

// ---- hdl/sdadc_timer.sv ----
// Conversion period timer for one converter, counting modulator ticks.
// Assumes mod_tick is a one-cycle enable at the modulator rate on the same clock.
`timescale 1ns/10ps
module sdadc_timer
  import sdadc_pkg::*;
#(
  parameter int CW = 13
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mod_tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [7:0] dec_factor,
  output logic period_end,
  output logic result_valid
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [1:0] periods;
    logic period_end;
    logic result_valid;
  } sdadc_timer_state_t;

  sdadc_timer_state_t s;
  sdadc_timer_state_t next_s;
  logic [CW-1:0] limit;

  // The limit follows the factor live, so a calibration override stretches the running period.
  assign limit = CW'(DEC_MULT) * CW'(dec_factor);

  always_comb begin
    next_s = s;
    next_s.period_end = 1'b0;
    next_s.result_valid = 1'b0;
    if (!run || restart) begin
      next_s.cnt = '0;
      next_s.periods = '0;
    end else if (mod_tick) begin
      if (s.cnt >= limit - CW'(1)) begin
        next_s.cnt = '0;
        next_s.period_end = 1'b1;
        // Chopping needs two whole periods before the first result settles.
        if (s.periods >= 2'(FIRST_RESULT_PERIODS - 1)) begin
          next_s.result_valid = 1'b1;
        end
        if (s.periods < 2'(FIRST_RESULT_PERIODS)) begin
          next_s.periods = s.periods + 2'h1;
        end
      end else begin
        next_s.cnt = s.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign period_end = s.period_end;
  assign result_valid = s.result_valid;

endmodule

// ---- hdl/sdadc_config.sv ----
// Configuration registers and output timing for the primary and auxiliary converters.
// Assumes the core drives one-cycle sfr_wr and sfr_rd strobes on clk_sys, and that the
// converter filters present signed two's-complement samples on prim_raw and aux_raw.
`timescale 1ns/10ps
module sdadc_config
  import sdadc_pkg::*;
#(
  parameter int PRIMARY_W = 24,
  parameter int AUX_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic primary_active,
  input wire logic aux_converter_enable,
  input wire logic cal_active,
  input wire logic [PRIMARY_W-1:0] prim_raw,
  input wire logic [AUX_W-1:0] aux_raw,
  output logic [2:0] primary_range,
  output logic primary_ext_reference_sel,
  output logic [1:0] primary_channel,
  output logic aux_ext_reference_sel,
  output logic [3:0] aux_input_sel,
  output logic primary_converter_reset,
  output logic aux_converter_reset,
  output logic mod_clk_tick,
  output logic [7:0] decimation_effective,
  output logic [PRIMARY_W-1:0] prim_result,
  output logic prim_result_valid,
  output logic [AUX_W-1:0] aux_result,
  output logic aux_result_valid
);

  localparam int TIMER_W = 13;

  typedef struct packed {
    logic [7:0] primary_converter_control;
    logic [7:0] aux_converter_control;
    logic [7:0] decimation_rate;
    logic [7:0] rdata;
    logic aux_en_q;
    logic prim_rst;
    logic aux_rst;
    logic [MOD_ACC_W-1:0] mod_acc;
    logic mod_tick;
    logic [3:0] aux_sel;
    logic [7:0] eff_dec;
    logic [PRIMARY_W-1:0] prim_result;
    logic prim_valid;
    logic [AUX_W-1:0] aux_result;
    logic aux_valid;
  } sdadc_cfg_state_t;

  sdadc_cfg_state_t s;
  sdadc_cfg_state_t next_s;

  logic prim_sample;
  logic aux_sample;
  logic wr_primary;
  logic wr_aux;
  logic wr_decim;

  assign wr_primary = sfr_wr && (sfr_addr == PRIMARY_CONVERTER_CONTROL_ADDR);
  assign wr_aux = sfr_wr && (sfr_addr == AUX_CONVERTER_CONTROL_ADDR);
  assign wr_decim = sfr_wr && (sfr_addr == DECIMATION_RATE_ADDR);

  // Signed sample to output code. Unipolar spans only the positive half, so negative
  // samples clamp to zero and positive ones are doubled with saturation.
  function automatic logic [PRIMARY_W-1:0] code_primary(input logic [PRIMARY_W-1:0] raw,
                                                        input logic unipolar);
    logic [PRIMARY_W-1:0] res;
    res = '0;
    if (!unipolar) begin
      res = raw ^ PRIMARY_BIPOLAR_ZERO;
    end else if (raw[PRIMARY_W-1]) begin
      res = '0;
    end else if (raw[PRIMARY_W-2]) begin
      res = '1;
    end else begin
      res = {raw[PRIMARY_W-2:0], 1'b0};
    end
    return res;
  endfunction

  function automatic logic [AUX_W-1:0] code_aux(input logic [AUX_W-1:0] raw, input logic unipolar);
    logic [AUX_W-1:0] res;
    res = '0;
    if (!unipolar) begin
      res = raw ^ AUX_BIPOLAR_ZERO;
    end else if (raw[AUX_W-1]) begin
      res = '0;
    end else if (raw[AUX_W-2]) begin
      res = '1;
    end else begin
      res = {raw[AUX_W-2:0], 1'b0};
    end
    return res;
  endfunction

  always_comb begin
    next_s = s;
    next_s.prim_rst = 1'b0;
    next_s.aux_rst = 1'b0;
    next_s.prim_valid = 1'b0;
    next_s.aux_valid = 1'b0;
    next_s.mod_tick = 1'b0;
    next_s.aux_en_q = aux_converter_enable;

    // Fractional divider: the modulator rate does not divide the core clock evenly,
    // so an accumulator spreads the ticks with at most one cycle of jitter.
    if (s.mod_acc + MOD_ACC_W'(MOD_HZ) >= MOD_ACC_W'(CLK_HZ)) begin
      next_s.mod_acc = s.mod_acc + MOD_ACC_W'(MOD_HZ) - MOD_ACC_W'(CLK_HZ);
      next_s.mod_tick = 1'b1;
    end else begin
      next_s.mod_acc = s.mod_acc + MOD_ACC_W'(MOD_HZ);
    end

    // Reserved bits are masked at the write, so they store and read as zero.
    if (wr_primary) begin
      next_s.primary_converter_control = sfr_wdata & PRIMARY_CONTROL_MASK;
      // A primary change while the primary converter is active restarts both converters.
      if (primary_active) begin
        next_s.prim_rst = 1'b1;
        next_s.aux_rst = 1'b1;
      end
    end
    if (wr_aux) begin
      next_s.aux_converter_control = sfr_wdata & AUX_CONTROL_MASK;
      next_s.aux_rst = 1'b1;
    end
    if (aux_converter_enable && !s.aux_en_q) begin
      next_s.aux_rst = 1'b1;
    end
    if (wr_decim && !primary_active && !aux_converter_enable) begin
      next_s.decimation_rate = sfr_wdata;
    end

    // Calibration overrides the factor without touching the stored register.
    next_s.eff_dec = cal_active ? DECIMATION_CAL : s.decimation_rate;

    // One-hot positive-input select; the negative input is always analog ground.
    case (s.aux_converter_control[AUX_CH_HI:AUX_CH_LO])
      AUX_CH_INPUT_THREE: next_s.aux_sel = 4'h1;
      AUX_CH_INPUT_FOUR: next_s.aux_sel = 4'h2;
      AUX_CH_TEMP_SENSOR: next_s.aux_sel = 4'h4;
      AUX_CH_INPUT_FIVE: next_s.aux_sel = 4'h8;
      default: next_s.aux_sel = 4'h0;
    endcase

    if (prim_sample) begin
      next_s.prim_result = code_primary(prim_raw, s.primary_converter_control[PRI_UNI_BIT]);
      next_s.prim_valid = 1'b1;
    end
    // The temperature sensor is trimmed so a signed zero means zero degrees; bipolar
    // coding then places it at 8000 with one count per degree in the high byte.
    if (aux_sample) begin
      next_s.aux_result = code_aux(aux_raw, s.aux_converter_control[AUX_UNI_BIT]);
      next_s.aux_valid = 1'b1;
    end

    next_s.rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        PRIMARY_CONVERTER_CONTROL_ADDR: next_s.rdata = s.primary_converter_control;
        AUX_CONVERTER_CONTROL_ADDR: next_s.rdata = s.aux_converter_control;
        DECIMATION_RATE_ADDR: next_s.rdata = s.decimation_rate;
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.primary_converter_control <= PRIMARY_CONVERTER_CONTROL_RST;
      s.aux_converter_control <= AUX_CONVERTER_CONTROL_RST;
      s.decimation_rate <= DECIMATION_RATE_RST;
      s.eff_dec <= DECIMATION_RATE_RST;
      s.aux_sel <= 4'h1;
    end else begin
      s <= next_s;
    end
  end

  // Both timers share the effective factor, so both converters update at one rate.
  sdadc_timer #(
    .CW(TIMER_W)
  ) u_primary_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mod_tick(s.mod_tick),
    .run(primary_active),
    .restart(s.prim_rst),
    .dec_factor(s.eff_dec),
    .period_end(),
    .result_valid(prim_sample)
  );

  // The auxiliary timer restarts alone, so a running primary conversion is untouched.
  sdadc_timer #(
    .CW(TIMER_W)
  ) u_aux_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mod_tick(s.mod_tick),
    .run(aux_converter_enable),
    .restart(s.aux_rst),
    .dec_factor(s.eff_dec),
    .period_end(),
    .result_valid(aux_sample)
  );

  assign sfr_rdata = s.rdata;
  assign primary_range = s.primary_converter_control[PRI_RANGE_HI:PRI_RANGE_LO];
  assign primary_ext_reference_sel = s.primary_converter_control[PRI_EXT_REF_BIT];
  assign primary_channel = s.primary_converter_control[PRI_CH_HI:PRI_CH_LO];
  // No range field exists on the auxiliary side; its span follows the chosen reference.
  assign aux_ext_reference_sel = s.aux_converter_control[AUX_EXT_REF_BIT];
  assign aux_input_sel = s.aux_sel;
  assign primary_converter_reset = s.prim_rst;
  assign aux_converter_reset = s.aux_rst;
  assign mod_clk_tick = s.mod_tick;
  assign decimation_effective = s.eff_dec;
  assign prim_result = s.prim_result;
  assign prim_result_valid = s.prim_valid;
  assign aux_result = s.aux_result;
  assign aux_result_valid = s.aux_valid;

endmodule

// ---- bench/sdadc_monitor.sv ----
// Concurrent checks on the ports of the converter configuration block.
// Assumes it is bound to sdadc_config and that reset is held low before the first check.
`timescale 1ns/10ps
module sdadc_monitor
  import sdadc_pkg::*;
#(
  parameter int PRIMARY_W = 24,
  parameter int AUX_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic primary_active,
  input wire logic aux_converter_enable,
  input wire logic cal_active,
  input wire logic [2:0] primary_range,
  input wire logic aux_ext_reference_sel,
  input wire logic [3:0] aux_input_sel,
  input wire logic primary_converter_reset,
  input wire logic aux_converter_reset,
  input wire logic [7:0] decimation_effective
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic w2 = sfr_wr && sfr_addr == PRIMARY_CONVERTER_CONTROL_ADDR;
  wire logic w3 = sfr_wr && sfr_addr == AUX_CONVERTER_CONTROL_ADDR;
  wire logic w4 = sfr_wr && sfr_addr == DECIMATION_RATE_ADDR;
  rsv_read_a: assert property ($past(sfr_rd && sfr_addr == AUX_CONVERTER_CONTROL_ADDR) |-> sfr_rdata[2:0] == 3'h0 && !sfr_rdata[7])
    else $error("aux control read shows reserved bits set");
  range_follow_a: assert property (w2 |=> primary_range == $past(sfr_wdata[2:0]))
    else $error("primary range does not follow the write");
  auxref_follow_a: assert property (w3 |=> aux_ext_reference_sel == $past(sfr_wdata[6]))
    else $error("aux reference select does not follow the write");
  chan_sel_a: assert property (w3 |=> ##1 aux_input_sel == 4'h1 << $past(sfr_wdata[5:4], 2))
    else $error("aux input select is not the decoded channel");
  dec_lock_a: assert property (w4 && (primary_active || aux_converter_enable) && !cal_active && !$past(w4) && !$past(cal_active) |=> (cal_active || $stable(decimation_effective)) [*2])
    else $error("decimation changed by a locked write");
  cal_ff_a: assert property (cal_active && $past(cal_active) |-> decimation_effective == DECIMATION_CAL)
    else $error("calibration does not run at maximum decimation");
  aux_wr_rst_a: assert property (w3 |=> aux_converter_reset)
    else $error("aux control write gave no aux reset");
  pri_rst_cause_a: assert property (primary_converter_reset |-> $past(w2 && primary_active))
    else $error("primary reset without a primary write while active");
  en_rise_rst_a: assert property ($rose(aux_converter_enable) |-> ##[1:2] aux_converter_reset)
    else $error("aux enable rise gave no aux reset");
  cover property (w4 && primary_active);
  cover property (cal_active ##2 cal_active);
  cover property (primary_converter_reset);
endmodule

bind sdadc_config sdadc_monitor #(.PRIMARY_W(PRIMARY_W), .AUX_W(AUX_W)) i_mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .primary_active(primary_active), .aux_converter_enable(aux_converter_enable), .cal_active(cal_active),
  .primary_range(primary_range), .aux_ext_reference_sel(aux_ext_reference_sel), .aux_input_sel(aux_input_sel),
  .primary_converter_reset(primary_converter_reset), .aux_converter_reset(aux_converter_reset),
  .decimation_effective(decimation_effective));

// ---- bench/testbench.sv ----
// Self-checking bench for the converter configuration block.
// Assumes sdadc_config with its bound monitor; inputs change on the falling edge.
`timescale 1ns/10ps
module testbench;
  import sdadc_pkg::*;
  logic clk_sys = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, primary_active = 0, aux_converter_enable = 0, cal_active = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, decimation_effective, d;
  logic [23:0] prim_raw = 24'h000000, prim_result;
  logic [15:0] aux_raw = 16'h0000, aux_result, lfsr = 16'h7A5A;
  logic [2:0] primary_range;
  logic [1:0] primary_channel;
  logic [3:0] aux_input_sel;
  logic primary_ext_reference_sel, aux_ext_reference_sel, primary_converter_reset, aux_converter_reset;
  logic mod_clk_tick, prim_result_valid, aux_result_valid;
  logic [7:0] exp_q[$];
  int n_errors = 0, checked = 0, t, first, v = 0;
  sdadc_config i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .primary_active(primary_active),
    .aux_converter_enable(aux_converter_enable), .cal_active(cal_active), .prim_raw(prim_raw), .aux_raw(aux_raw),
    .primary_range(primary_range), .primary_ext_reference_sel(primary_ext_reference_sel),
    .primary_channel(primary_channel), .aux_ext_reference_sel(aux_ext_reference_sel), .aux_input_sel(aux_input_sel),
    .primary_converter_reset(primary_converter_reset), .aux_converter_reset(aux_converter_reset),
    .mod_clk_tick(mod_clk_tick), .decimation_effective(decimation_effective), .prim_result(prim_result),
    .prim_result_valid(prim_result_valid), .aux_result(aux_result), .aux_result_valid(aux_result_valid));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] got);
    checked++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  // The expected byte is queued now and compared by the watcher one cycle later.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_sys);
    sfr_rd = 1'b0;
  endtask
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (sfr_rd === 1'b1 && exp_q.size() > 0) begin
      @(negedge clk_sys);
      check("sfr_rdata", exp_q.pop_front(), sfr_rdata);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    check("decimation_effective", 8'h45, decimation_effective);
    rd(PRIMARY_CONVERTER_CONTROL_ADDR, 8'h07);
    rd(AUX_CONVERTER_CONTROL_ADDR, 8'h00);
    rd(DECIMATION_RATE_ADDR, 8'h45);
    rd(8'hD5, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      prim_raw = {lfsr, lfsr[15:8]};
      aux_raw = ~lfsr;
      wr(PRIMARY_CONVERTER_CONTROL_ADDR, lfsr[7:0]);
      check("primary_range", {5'h00, lfsr[2:0]}, {5'h00, primary_range});
      check("primary_ext_reference_sel", {7'h00, lfsr[6]}, {7'h00, primary_ext_reference_sel});
      check("primary_channel", {6'h00, lfsr[5:4]}, {6'h00, primary_channel});
      rd(PRIMARY_CONVERTER_CONTROL_ADDR, lfsr[7:0] & 8'h7F);
    end
    // The temperature sensor pass is set up with internal reference and bipolar coding.
    for (int i = 3; i >= 0; i--) begin
      lfsr = nxt(lfsr);
      d = (i == 2) ? {lfsr[7], 3'h2, lfsr[3:0] & 4'h7} : {lfsr[7:6], i[1:0], lfsr[3:0]};
      wr(AUX_CONVERTER_CONTROL_ADDR, d);
      check("aux_ext_reference_sel", {7'h00, d[6]}, {7'h00, aux_ext_reference_sel});
      @(negedge clk_sys);
      check("aux_input_sel", 8'h01 << d[5:4], {4'h0, aux_input_sel});
      rd(AUX_CONVERTER_CONTROL_ADDR, d & 8'h78);
    end
    wr(DECIMATION_RATE_ADDR, 8'h0D);
    rd(DECIMATION_RATE_ADDR, 8'h0D);
    for (int i = 0; i < 2; i++) begin
      primary_active = (i == 0);
      aux_converter_enable = (i == 1);
      wr(PRIMARY_CONVERTER_CONTROL_ADDR, 8'h07);
      wr(DECIMATION_RATE_ADDR, 8'hFF);
      rd(DECIMATION_RATE_ADDR, 8'h0D);
    end
    aux_converter_enable = 1'b0;
    cal_active = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("decimation_effective", 8'hFF, decimation_effective);
    rd(DECIMATION_RATE_ADDR, 8'h0D);
    cal_active = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("decimation_effective", 8'h0D, decimation_effective);
    aux_converter_enable = 1'b1;
    t = 0;
    repeat (3) begin
      @(negedge clk_sys);
      t += aux_converter_reset * 8 + primary_converter_reset;
    end
    check("reset_pulses", 8'h08, t[7:0]);
    aux_converter_enable = 1'b0;
    wr(DECIMATION_RATE_ADDR, 8'hFF);
    rd(DECIMATION_RATE_ADDR, 8'hFF);
    // Both converters run here; a whole period is far longer than this window, so no result may appear.
    primary_active = 1'b1;
    aux_converter_enable = 1'b1;
    first = -1;
    t = 0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      v += prim_result_valid + aux_result_valid;
      if (mod_clk_tick === 1'b1) begin
        if (first >= 0) begin
          t = i - first;
          break;
        end
        first = i;
      end
    end
    check("tick_spacing", 8'h01, {7'h00, t inside {762, 763}});
    check("early_results", 8'h00, v[7:0]);
    check("results_held", 8'h00, {7'h00, |{prim_result, aux_result}});
    repeat (2) @(negedge clk_sys);
    end_of_test();
  end
endmodule
